/* logic/tpo_top.sv */
// Thermometer pulse output with measurement loop and APB registers
`timescale 1ns/1ps
`include "tpo_consts.svh"

// Summary of operation
// - Period opens with high eighth-period start buffer
// - Data high time spans zero to half period
// - Storage double error gives 0.875 duty band
// - Extended format repeats each period 2N+1 times
// - Extended period doubled, second field at 1.125
// - Extended error shows 43.75 and 93.75 percent
// - Error band only in automotive variants
// - Object rescaled to ten bits over range
// - Object RAM doubled onto the range-cell scale
// - Ambient range cell: high byte max, low min
// - Ambient bytes map 0.64 degree steps from -38.2
// - Long serial clock low hands pin to SMBus
// - Pulse output returns only after power or wake
// - Pulses disabled in config: SMBus once init is done
// - Ambient result kept at 0.02 K steps
// - Object results kept at 0.02 K steps
// - Reset loads calibration, selects sensors, loops
// - Ambient: fixed offset filter then programmable filter
// - Object: offset stage, second sensor stage optional
// - Two-bit select chooses the two data sources
// - Period comes from clock, programmable divider
module tpo_top #(
  parameter int REQ_CYCLES = `TPO_REQ_CYC,
  parameter bit AUTO_GRADE = 1'b1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // APB register port
  input wire tpo_pkg::tpo_apb_req_t i_apb,
  output tpo_pkg::tpo_apb_rsp_t o_apb,
  // Measurement front end
  input wire logic i_adc_valid,
  input wire logic [15:0] i_adc_data,
  output logic [2:0] o_adc_chan,
  // Nonvolatile status and straps
  input wire logic i_nv_pwm_en,
  input wire logic i_nvm_double_err,
  input wire logic i_wake,
  // Serial clock and shared data pin
  input wire logic i_scl,
  input wire logic i_sda_in,
  output logic o_pin_out,
  output logic o_pin_oe,
  output logic o_smbus_mode
);
  // ==========================================
  // Registers
  logic [9:0] ctrl_ff;        // Format, select, repeat
  logic [15:0] period_ff;     // Tick divider
  logic [15:0] obj_lo_ff;     // object_range_low
  logic [15:0] obj_hi_ff;     // object_range_high
  logic [15:0] amb_rng_ff;    // ambient_range_cell
  logic [7:0] filt_ff;        // IIR [7:4], FIR [2:0]
  logic [31:0] prdata_ff;     // Latched read data
  logic [15:0] amb_ofs_ff;    // Ambient offset result
  logic [15:0] amb_filt_ff;   // ambient_filtered_result
  logic [15:0] amb_fin_ff;    // ambient_final_result
  logic [15:0] ir_ofs_ff;     // infrared_offset_result
  logic [15:0] obj1_ff;       // Object 1 result
  logic [15:0] obj2_ff;       // Object 2 result
  // Loop state
  tpo_pkg::tpo_state_t st_ff;
  logic [7:0] icnt_ff;        // Init wait
  logic [23:0] acc_ff;        // FIR sum
  logic [7:0] scnt_ff;        // FIR sample count
  logic fld_ff;               // Field being rescaled
  logic [26:0] rem_ff;        // Divider remainder
  logic [16:0] den_ff;        // Divider denominator
  logic [9:0] q_ff;           // Quotient
  logic [3:0] dcnt_ff;        // Quotient bit index
  logic [9:0] res0_ff;        // Fresh field values
  logic [9:0] res1_ff;
  logic [9:0] pend0_ff;       // Waiting for period start
  logic [9:0] pend1_ff;
  // Pulse state
  logic [15:0] div_ff;
  logic [11:0] ph_ff;
  logic [9:0] cur0_ff;
  logic [9:0] cur1_ff;
  logic ext_ff;
  logic err_ff;
  logic [5:0] rep_ff;
  logic nv_en_ff;             // Captured strap
  logic act_ff;               // Pulse output on
  logic init_done_ff;
  logic [23:0] req_ff;        // Serial clock low count
  logic pin_ff;
  // Loop states named locally; the package stays unimported
  localparam tpo_pkg::tpo_state_t ST_INIT = tpo_pkg::ST_INIT, ST_SEL = tpo_pkg::ST_SEL,
    ST_AOFS = tpo_pkg::ST_AOFS, ST_ASEN = tpo_pkg::ST_ASEN, ST_IROFS = tpo_pkg::ST_IROFS,
    ST_IR1 = tpo_pkg::ST_IR1, ST_IR2 = tpo_pkg::ST_IR2, ST_DIVST = tpo_pkg::ST_DIVST,
    ST_DIV = tpo_pkg::ST_DIV, ST_LOAD = tpo_pkg::ST_LOAD;

  // ==========================================
  // APB decode
  wire setup = i_apb.psel && !i_apb.penable;
  wire access = i_apb.psel && i_apb.penable;
  wire [7:0] ad = i_apb.paddr;
  wire hit_rw = ad == `TPO_CTRL_OFS || ad == `TPO_PERIOD_OFS || ad == `TPO_OBJ_LOW_OFS
    || ad == `TPO_OBJ_HIGH_OFS || ad == `TPO_AMB_RANGE_OFS || ad == `TPO_FILT_OFS;
  wire hit_ro = ad == `TPO_STATUS_OFS || ad == `TPO_AMB_OFS_OFS
    || ad == `TPO_AMB_FILT_OFS || ad == `TPO_AMB_FINAL_OFS || ad == `TPO_IR_OFS_OFS
    || ad == `TPO_OBJ1_OFS || ad == `TPO_OBJ2_OFS || ad == `TPO_PWM_VAL_OFS;
  wire bad = !(hit_rw || (hit_ro && !i_apb.pwrite));
  wire wr = access && i_apb.pwrite && hit_rw;
  wire [31:0] stat = {28'h0000000, err_ff, o_smbus_mode, act_ff, init_done_ff};
  wire [31:0] rsel =
    ad == `TPO_CTRL_OFS ? {22'h000000, ctrl_ff} :
    ad == `TPO_PERIOD_OFS ? {16'h0000, period_ff} :
    ad == `TPO_OBJ_LOW_OFS ? {16'h0000, obj_lo_ff} :
    ad == `TPO_OBJ_HIGH_OFS ? {16'h0000, obj_hi_ff} :
    ad == `TPO_AMB_RANGE_OFS ? {16'h0000, amb_rng_ff} :
    ad == `TPO_FILT_OFS ? {24'h000000, filt_ff} :
    ad == `TPO_STATUS_OFS ? stat :
    ad == `TPO_AMB_OFS_OFS ? {16'h0000, amb_ofs_ff} :
    ad == `TPO_AMB_FILT_OFS ? {16'h0000, amb_filt_ff} :
    ad == `TPO_AMB_FINAL_OFS ? {16'h0000, amb_fin_ff} :
    ad == `TPO_IR_OFS_OFS ? {16'h0000, ir_ofs_ff} :
    ad == `TPO_OBJ1_OFS ? {16'h0000, obj1_ff} :
    ad == `TPO_OBJ2_OFS ? {16'h0000, obj2_ff} :
    ad == `TPO_PWM_VAL_OFS ? {6'h00, cur1_ff, 6'h00, cur0_ff} : 32'h00000000;
  // Zero-wait slave; error on unmapped or read-only write
  assign o_apb = '{pready: 1'b1, pslverr: access && bad, prdata: prdata_ff};

  // Register writes at the access edge
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      ctrl_ff <= `TPO_CTRL_RST;
      period_ff <= `TPO_PERIOD_RST;
      obj_lo_ff <= `TPO_OBJ_LOW_RST;
      obj_hi_ff <= `TPO_OBJ_HIGH_RST;
      amb_rng_ff <= `TPO_AMB_RANGE_RST;
      filt_ff <= `TPO_FILT_RST;
    end
    else if (wr)
    begin
      if (ad == `TPO_CTRL_OFS) ctrl_ff <= i_apb.pwdata[9:0];
      if (ad == `TPO_PERIOD_OFS) period_ff <= i_apb.pwdata[15:0];
      if (ad == `TPO_OBJ_LOW_OFS) obj_lo_ff <= i_apb.pwdata[15:0];
      if (ad == `TPO_OBJ_HIGH_OFS) obj_hi_ff <= i_apb.pwdata[15:0];
      if (ad == `TPO_AMB_RANGE_OFS) amb_rng_ff <= i_apb.pwdata[15:0];
      if (ad == `TPO_FILT_OFS) filt_ff <= i_apb.pwdata[7:0];
    end
  end

  // Read data latched in the setup cycle
  always_ff @(posedge i_clk)
  begin
    if (i_reset) prdata_ff <= 32'h00000000;
    else if (setup) prdata_ff <= rsel;
  end

  // ==========================================
  // Measurement loop decode
  wire [1:0] dsel = ctrl_ff[`TPO_CTRL_SEL_HI:`TPO_CTRL_SEL_LO];
  wire fixed_len = st_ff == ST_AOFS || st_ff == ST_IROFS;
  wire [2:0] fl = fixed_len ? `TPO_FIX_FIR : filt_ff[2:0];
  wire [3:0] il = fixed_len ? {1'b0, `TPO_FIX_IIR} : filt_ff[7:4];
  wire [7:0] last_s = 8'((9'h001 << fl) - 9'h001);
  wire [23:0] acc_n = acc_ff + {8'h00, i_adc_data};
  wire [15:0] fir = 16'(acc_n >> fl);
  wire sample_end = i_adc_valid && scnt_ff == last_s;
  // IIR step toward the FIR value for the active stage
  wire [15:0] iir_old = st_ff == ST_AOFS ? amb_ofs_ff : st_ff == ST_ASEN ? amb_filt_ff :
    st_ff == ST_IROFS ? ir_ofs_ff : st_ff == ST_IR1 ? obj1_ff : obj2_ff;
  wire signed [16:0] iir_d = $signed({1'b0, fir}) - $signed({1'b0, iir_old});
  wire [15:0] iir_new = 16'($signed({1'b0, iir_old}) + (iir_d >>> il));
  // Offset compensation with floor at zero
  wire [15:0] amb_fin = iir_new > amb_ofs_ff ? iir_new - amb_ofs_ff : 16'h0000;
  wire [15:0] obj_cmp = iir_new > ir_ofs_ff ? iir_new - ir_ofs_ff : 16'h0000;
  // Source and range for the field being rescaled
  wire amb_src = !fld_ff && !dsel[1];
  wire [15:0] obj_src = fld_ff ? (dsel == 2'b00 ? obj1_ff : obj2_ff) :
    (dsel == 2'b11 ? obj1_ff : obj2_ff);
  // Ambient bytes step 32 RAM counts from the -38.2 point
  wire [16:0] amb_lo = `TPO_AMB_BASE + (17'(amb_rng_ff[7:0]) << `TPO_AMB_SHIFT);
  wire [16:0] amb_hi = `TPO_AMB_BASE + (17'(amb_rng_ff[15:8]) << `TPO_AMB_SHIFT);
  // Object RAM doubled onto the 0.01 degree range-cell scale
  wire [16:0] x = amb_src ? {1'b0, amb_fin_ff} : {obj_src, 1'b0};
  wire [16:0] lo = amb_src ? amb_lo : {1'b0, obj_lo_ff};
  wire [16:0] hi = amb_src ? amb_hi : {1'b0, obj_hi_ff};
  wire below = x <= lo;
  wire above = x >= hi;
  wire [16:0] xd = x - lo;
  wire [26:0] num = (27'(xd) << 10) - 27'(xd);
  wire [26:0] dsh = 27'(den_ff) << dcnt_ff;
  wire dfit = rem_ff >= dsh;
  wire [9:0] q_n = dfit ? (q_ff | 10'(11'h001 << dcnt_ff)) : q_ff;
  wire [9:0] dval = below ? 10'h000 : `TPO_FULL_SCALE;
  // Channel to measure for each stage
  assign o_adc_chan = st_ff == ST_AOFS ? 3'h0 :
    st_ff == ST_ASEN ? {2'b00, ctrl_ff[`TPO_CTRL_TSEL]} + 3'h1 :
    st_ff == ST_IROFS ? 3'h3 : st_ff == ST_IR1 ? 3'h4 : 3'h5;

  // Measurement, filtering and rescale sequencer
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      st_ff <= ST_INIT;
      icnt_ff <= 8'h00;
      acc_ff <= 24'h000000;
      scnt_ff <= 8'h00;
      amb_ofs_ff <= 16'h0000;
      amb_filt_ff <= 16'h0000;
      amb_fin_ff <= 16'h0000;
      ir_ofs_ff <= 16'h0000;
      obj1_ff <= 16'h0000;
      obj2_ff <= 16'h0000;
      fld_ff <= 1'b0;
      rem_ff <= 27'h0000000;
      den_ff <= 17'h00000;
      q_ff <= 10'h000;
      dcnt_ff <= 4'h0;
      res0_ff <= 10'h000;
      res1_ff <= 10'h000;
      pend0_ff <= 10'h000;
      pend1_ff <= 10'h000;
      init_done_ff <= 1'b0;
    end
    else
    begin
      case (st_ff)
        // Calibration load wait
        ST_INIT:
        begin
          icnt_ff <= icnt_ff + 8'h01;
          if (icnt_ff == 8'(`TPO_INIT_CYC - 1)) st_ff <= ST_SEL;
        end
        // Sensor selection settled; loop begins
        ST_SEL:
        begin
          init_done_ff <= 1'b1;
          st_ff <= ST_AOFS;
        end
        // Filter stages
        ST_AOFS, ST_ASEN, ST_IROFS, ST_IR1, ST_IR2:
        begin
          if (i_adc_valid)
          begin
            acc_ff <= sample_end ? 24'h000000 : acc_n;
            scnt_ff <= sample_end ? 8'h00 : scnt_ff + 8'h01;
          end
          if (sample_end)
          begin
            case (st_ff)
              ST_AOFS:
              begin
                amb_ofs_ff <= iir_new;
                st_ff <= ST_ASEN;
              end
              ST_ASEN:
              begin
                amb_filt_ff <= iir_new;
                amb_fin_ff <= amb_fin;
                st_ff <= ST_IROFS;
              end
              ST_IROFS:
              begin
                ir_ofs_ff <= iir_new;
                st_ff <= ST_IR1;
              end
              ST_IR1:
              begin
                obj1_ff <= obj_cmp;
                st_ff <= ctrl_ff[`TPO_CTRL_DUAL_IR] ? ST_IR2 : ST_DIVST;
              end
              default:
              begin
                obj2_ff <= obj_cmp;
                st_ff <= ST_DIVST;
              end
            endcase
          end
        end
        // Clamp or start the divide
        ST_DIVST:
        begin
          if (below || above)
          begin
            if (fld_ff) res1_ff <= dval;
            else res0_ff <= dval;
            fld_ff <= !fld_ff;
            st_ff <= fld_ff ? ST_LOAD : ST_DIVST;
          end
          else
          begin
            rem_ff <= num;
            den_ff <= hi - lo;
            q_ff <= 10'h000;
            dcnt_ff <= 4'h9;
            st_ff <= ST_DIV;
          end
        end
        // One quotient bit per cycle
        ST_DIV:
        begin
          if (dfit) rem_ff <= rem_ff - dsh;
          q_ff <= q_n;
          dcnt_ff <= dcnt_ff - 4'h1;
          if (dcnt_ff == 4'h0)
          begin
            if (fld_ff) res1_ff <= q_n;
            else res0_ff <= q_n;
            fld_ff <= !fld_ff;
            st_ff <= fld_ff ? ST_LOAD : ST_DIVST;
          end
        end
        // Hand both fields to the pulse generator
        ST_LOAD:
        begin
          pend0_ff <= res0_ff;
          pend1_ff <= res1_ff;
          st_ff <= ST_AOFS;
        end
        default: st_ff <= ST_INIT;
      endcase
    end
  end

  // ==========================================
  // Pulse timing
  wire tick = div_ff == period_ff;
  wire [11:0] plen = ext_ff ? `TPO_EXT_LEN : `TPO_SGL_LEN;
  wire pend = tick && ph_ff == plen;
  wire [4:0] rep_n = ctrl_ff[`TPO_CTRL_REP_HI:`TPO_CTRL_REP_LO];
  wire new_ext = ctrl_ff[`TPO_CTRL_EXT];
  wire [11:0] hi0 = err_ff ? `TPO_SGL_ERR_END : `TPO_START_END + {2'b00, cur0_ff};
  wire [11:0] hi1 = err_ff ? `TPO_EXT_ERR2_END : `TPO_F2_START + {2'b00, cur1_ff};
  wire f1_hi = ph_ff < hi0;
  wire f2_hi = ext_ff && ph_ff >= `TPO_F2_START && ph_ff < hi1;
  wire pin_hi = f1_hi || f2_hi;
  // Error band only where the variant carries it
  wire err_in = AUTO_GRADE && i_nvm_double_err;
  wire req_hit = act_ff && !i_scl && req_ff == 24'(REQ_CYCLES - 1);

  // Tick divider and period phase
  always_ff @(posedge i_clk)
  begin
    if (i_reset || !act_ff)
    begin
      div_ff <= 16'h0000;
      ph_ff <= 12'h000;
    end
    else
    begin
      div_ff <= tick ? 16'h0000 : div_ff + 16'h0001;
      if (tick) ph_ff <= pend ? 12'h000 : ph_ff + 12'h001;
    end
  end

  // Period-start adoption of data, format and repeats
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      cur0_ff <= 10'h000;
      cur1_ff <= 10'h000;
      ext_ff <= 1'b0;
      err_ff <= 1'b0;
      rep_ff <= 6'h00;
    end
    else if (pend || !act_ff)
    begin
      if (rep_ff == 6'h00)
      begin
        cur0_ff <= pend0_ff;
        cur1_ff <= pend1_ff;
        ext_ff <= new_ext;
        rep_ff <= new_ext ? {rep_n, 1'b0} : 6'h00;
      end
      else rep_ff <= rep_ff - 6'h01;
      err_ff <= err_in;
    end
  end

  // Request detection and mode hand-over
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      nv_en_ff <= 1'b0;
      act_ff <= 1'b0;
      req_ff <= 24'h000000;
      pin_ff <= 1'b0;
    end
    else
    begin
      if (st_ff == ST_INIT) nv_en_ff <= i_nv_pwm_en;
      if (st_ff == ST_SEL) act_ff <= nv_en_ff;
      else if (i_wake) act_ff <= nv_en_ff;
      else if (req_hit) act_ff <= 1'b0;
      req_ff <= (act_ff && !i_scl && !req_hit) ? req_ff + 24'h000001 : 24'h000000;
      pin_ff <= act_ff && pin_hi;
    end
  end

  // Pin drive; data line ignored while pulses run
  assign o_pin_out = pin_ff;
  assign o_pin_oe = act_ff;
  assign o_smbus_mode = init_done_ff && !act_ff;

  // ==========================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic act_q;
  always_ff @(posedge i_clk) act_q <= act_ff;
  start_buf_a: assert property (act_ff && ph_ff < `TPO_START_END |-> pin_hi)
    else $error("start buffer not high");
  data_end_a: assert property (!err_ff && ph_ff >= 12'h500 |-> !f1_hi)
    else $error("data interval overran");
  err_band_a: assert property (err_ff && !ext_ff && ph_ff == 12'h6ff |-> pin_hi)
    else $error("single error band short");
  rep_load_a: assert property (pend && rep_ff == 6'h00 && new_ext
    |=> rep_ff == {$past(rep_n), 1'b0})
    else $error("repeat count wrong");
  gap_low_a: assert property (ext_ff && ph_ff >= 12'h800 && ph_ff < `TPO_F2_START
    |-> !pin_hi)
    else $error("field gap not low");
  ext_err_a: assert property (ext_ff && err_ff && ph_ff == 12'heff |-> pin_hi)
    else $error("extended error band short");
  req_off_a: assert property (req_hit && !i_wake && st_ff != ST_SEL
    |=> !act_ff && o_smbus_mode)
    else $error("request not honoured");
  stay_off_a: assert property (!act_ff && st_ff != ST_SEL && !i_wake |=> !act_ff)
    else $error("pulses resumed alone");
  nv_off_a: assert property (st_ff == ST_SEL && !nv_en_ff |=> o_smbus_mode)
    else $error("disabled pulses not smbus");
  clamp_lo_a: assert property (st_ff == ST_DIVST && below && !fld_ff
    |=> res0_ff == 10'h000)
    else $error("low clamp missing");
  adopt_a: assert property (act_q && act_ff && $changed(cur0_ff) |-> $past(pend))
    else $error("data changed mid period");
  ext_err_c: cover property (ext_ff && err_ff && pin_hi && ph_ff == 12'hd00);
  request_c: cover property (req_hit);
  divide_c: cover property (st_ff == ST_DIV && dcnt_ff == 4'h0);
  repeat_c: cover property (pend && rep_ff == 6'h01);
endmodule // tpo_top

/* logic/tpo_consts.svh */
// Constants for the thermometer pulse-output block
`ifndef TPO_CONSTS_SVH
`define TPO_CONSTS_SVH
// ==========================================
// Register byte offsets
`define TPO_CTRL_OFS 8'h00
`define TPO_PERIOD_OFS 8'h04
`define TPO_OBJ_LOW_OFS 8'h08
`define TPO_OBJ_HIGH_OFS 8'h0c
`define TPO_AMB_RANGE_OFS 8'h10
`define TPO_FILT_OFS 8'h14
`define TPO_STATUS_OFS 8'h18
`define TPO_AMB_OFS_OFS 8'h1c
`define TPO_AMB_FILT_OFS 8'h20
`define TPO_AMB_FINAL_OFS 8'h24
`define TPO_IR_OFS_OFS 8'h28
`define TPO_OBJ1_OFS 8'h2c
`define TPO_OBJ2_OFS 8'h30
`define TPO_PWM_VAL_OFS 8'h34
// ==========================================
// Control field positions
`define TPO_CTRL_EXT 0
`define TPO_CTRL_SEL_LO 1
`define TPO_CTRL_SEL_HI 2
`define TPO_CTRL_DUAL_IR 3
`define TPO_CTRL_REP_LO 4
`define TPO_CTRL_REP_HI 8
`define TPO_CTRL_TSEL 9
// ==========================================
// Reset values
`define TPO_CTRL_RST 10'h000
`define TPO_PERIOD_RST 16'h000b
`define TPO_OBJ_LOW_RST 16'h0000
`define TPO_OBJ_HIGH_RST 16'hffff
`define TPO_AMB_RANGE_RST 16'hff00
`define TPO_FILT_RST 8'h23
// ==========================================
// Pulse timing in ticks; one single period is 2048 ticks
`define TPO_SGL_LEN 12'h7ff
`define TPO_EXT_LEN 12'hfff
`define TPO_START_END 12'h100
`define TPO_SGL_ERR_END 12'h700
`define TPO_F2_START 12'h900
`define TPO_EXT_ERR2_END 12'hf00
// ==========================================
// Rescale and fixed filter constants
`define TPO_AMB_BASE 17'h02de4
`define TPO_AMB_SHIFT 5
`define TPO_FULL_SCALE 10'h3ff
`define TPO_FIX_FIR 3'h3
`define TPO_FIX_IIR 3'h3
// ==========================================
// Clock and wait times
`define TPO_CLK_HZ 25000000
`define TPO_TREQ_US 1000
`define TPO_INIT_NS 2000
`define TPO_INIT_CYC ((`TPO_INIT_NS * (`TPO_CLK_HZ / 1000000) + 999) / 1000)
`define TPO_REQ_CYC (`TPO_TREQ_US * (`TPO_CLK_HZ / 1000000))
`endif

/* logic/tpo_pkg.sv */
// Types for the thermometer pulse-output block
package tpo_pkg;
  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } tpo_apb_req_t;
  // APB answer to the master
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tpo_apb_rsp_t;
  // Measurement loop states
  typedef enum logic [3:0] {
    ST_INIT, ST_SEL, ST_AOFS, ST_ASEN, ST_IROFS, ST_IR1, ST_IR2,
    ST_DIVST, ST_DIV, ST_LOAD
  } tpo_state_t;
endpackage

/* sim/tpo_host_model.sv */
// Host model: drives the serial clock and captures pulse widths
`timescale 1ns/1ps
module tpo_host_model (
  // Clock
  input wire logic i_clk,
  // Pin and request command
  input wire logic i_pin,
  input wire logic i_oe,
  input wire logic i_req,
  // Serial clock and captures
  output logic o_scl,
  output int o_w1,
  output int o_w2,
  output int o_cnt
);
  int run = 0; // High time so far
  int fall_n = 0; // Pulses completed
  int gap = 0; // Clocks since last rise
  int r_gap = 0; // Rise-to-rise gap of current pulse
  // Clock held high except while a request is commanded
  assign o_scl = !i_req;
  assign o_cnt = fall_n;
  // Width capture; a released pin counts as low
  always @(posedge i_clk)
  begin
    gap <= gap + 1;
    if (i_pin === 1'b1 && i_oe === 1'b1)
    begin
      run <= run + 1;
      if (run == 0)
      begin
        r_gap <= gap;
        gap <= 1;
      end
    end
    else if (run != 0)
    begin
      // Rise 2304 after the previous one marks the second field
      if (r_gap == 2304)
        o_w2 <= run;
      else
        o_w1 <= run;
      fall_n <= fall_n + 1;
      run <= 0;
    end
  end
endmodule // tpo_host_model

/* sim/test_thermometer_pwm_output.sv */
// Testbench for the thermometer pulse-output block
`timescale 1ns/1ps
`include "tpo_consts.svh"
module test_thermometer_pwm_output;
  // ==========================================
  // Stimulus and observation
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  tpo_pkg::tpo_apb_req_t req = '0;
  tpo_pkg::tpo_apb_rsp_t rsp;
  logic adc_v = 1'b0;
  logic nv_err = 1'b0;
  logic wake = 1'b0;
  logic hreq = 1'b0;
  logic scl, pin, oe, smb;
  logic [2:0] chan;
  logic strap = 1'b1;
  logic [15:0] obj_d = 16'h0000;
  // Offset channels see zero, measuring channels the object value
  wire [15:0] adc_d = (chan == 3'h0 || chan == 3'h3) ? 16'h0000 : obj_d;
  logic [31:0] rd;
  logic se;
  int w1, w2, cnt;
  int error_cnt = 0;
  int total_checks = 0;
  // Reset-value table
  logic [7:0] ra [6] = '{`TPO_CTRL_OFS, `TPO_PERIOD_OFS, `TPO_OBJ_LOW_OFS,
    `TPO_OBJ_HIGH_OFS, `TPO_AMB_RANGE_OFS, `TPO_FILT_OFS};
  logic [31:0] rv [6] = '{32'h0, 32'h000b, 32'h0, 32'hffff, 32'hff00, 32'h23};
  // ==========================================
  // Instances
  tpo_top #(.REQ_CYCLES(20), .AUTO_GRADE(1'b1)) uut (.i_clk(i_clk), .i_reset(i_reset),
    .i_apb(req), .o_apb(rsp), .i_adc_valid(adc_v), .i_adc_data(adc_d),
    .o_adc_chan(chan), .i_nv_pwm_en(strap), .i_nvm_double_err(nv_err), .i_wake(wake),
    .i_scl(scl), .i_sda_in(1'b1), .o_pin_out(pin), .o_pin_oe(oe), .o_smbus_mode(smb));
  tpo_host_model host (.i_clk(i_clk), .i_pin(pin), .i_oe(oe), .i_req(hreq),
    .o_scl(scl), .o_w1(w1), .o_w2(w2), .o_cnt(cnt));
  // Clock and sample strobe every other cycle
  initial forever #20 i_clk = ~i_clk;
  always @(posedge i_clk) adc_v <= ~adc_v;
  // ==========================================
  // Tasks
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_hang;
    error_cnt++;
    $display("[ERR] %0t wait ran out", $time);
    test_done;
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge i_clk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 50);
    if (n >= 50)
      stop_hang;
    rd = rsp.prdata;
    se = rsp.pslverr;
    req <= '0;
  endtask
  // Wait for n captured pulses
  task automatic wait_p(input int n);
    int t, c0;
    c0 = cnt;
    t = 0;
    while (cnt < c0 + n && t < 30000)
    begin
      @(posedge i_clk);
      t++;
    end
    if (t >= 30000)
      stop_hang;
  endtask
  // Wait for the loop to reach the given ADC channel, then check it
  task automatic wait_chan(input logic [2:0] c);
    int t;
    t = 0;
    while (chan !== c && t < 400)
    begin
      @(posedge i_clk);
      t++;
    end
    chk({29'h0, chan}, {29'h0, c});
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    repeat (6) @(posedge i_clk);
    i_reset <= 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, rv[i]);
    end
    apb(1'b0, 8'h3c, 32'h0);
    chk({31'h0, se}, 32'h1);
    apb(1'b1, `TPO_STATUS_OFS, 32'hf);
    chk({31'h0, se}, 32'h1);
    // Range forces clamp to zero; one tick per clock
    apb(1'b1, `TPO_OBJ_LOW_OFS, 32'hfffe);
    apb(1'b1, `TPO_CTRL_OFS, 32'h6);
    apb(1'b1, `TPO_PERIOD_OFS, 32'h0);
    wait_p(3);
    chk(w1, 32'd256);
    apb(1'b0, `TPO_PWM_VAL_OFS, 32'h0);
    chk(rd, 32'h0);
    nv_err <= 1'b1;
    wait_p(3);
    chk(w1, 32'd1792);
    apb(1'b1, `TPO_CTRL_OFS, 32'h7);
    wait_p(6);
    chk(w1, 32'd1792);
    chk(w2, 32'd1536);
    nv_err <= 1'b0;
    wait_p(4);
    chk(w1, 32'd256);
    // Mid-range object value goes through the divider
    obj_d <= 16'h2000;
    apb(1'b1, `TPO_FILT_OFS, 32'h3);
    apb(1'b1, `TPO_OBJ_LOW_OFS, 32'h0);
    apb(1'b1, `TPO_OBJ_HIGH_OFS, 32'h8000);
    apb(1'b1, `TPO_CTRL_OFS, 32'h6);
    wait_p(3);
    chk(w1, 32'd767);
    apb(1'b0, `TPO_PWM_VAL_OFS, 32'h0);
    chk(rd, 32'h1ff);
    // Short clock-low does not hand over the pin
    hreq <= 1'b1;
    repeat (10) @(posedge i_clk);
    hreq <= 1'b0;
    repeat (3) @(posedge i_clk);
    chk({31'h0, oe}, 32'h1);
    hreq <= 1'b1;
    repeat (25) @(posedge i_clk);
    hreq <= 1'b0;
    repeat (3) @(posedge i_clk);
    chk({31'h0, oe}, 32'h0);
    chk({31'h0, smb}, 32'h1);
    repeat (3000) @(posedge i_clk);
    chk({31'h0, oe}, 32'h0);
    wake <= 1'b1;
    @(posedge i_clk);
    wake <= 1'b0;
    for (int t = 0; t < 200 && oe !== 1'b1; t++)
      @(posedge i_clk);
    chk({31'h0, oe}, 32'h1);
    // Second reset with pulses disabled in the strap
    strap <= 1'b0;
    i_reset <= 1'b1;
    repeat (6) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    chk({31'h0, smb}, 32'h0);
    wait_chan(3'h0);
    chk({31'h0, oe}, 32'h0);
    chk({31'h0, smb}, 32'h1);
    wait_chan(3'h3);
    wait_chan(3'h4);
    wake <= 1'b1;
    @(posedge i_clk);
    wake <= 1'b0;
    repeat (3) @(posedge i_clk);
    chk({31'h0, oe}, 32'h0);
    test_done;
  end
endmodule // test_thermometer_pwm_output
